/* File: bsa_bus_arbiter.v */
`timescale 1ns/100ps
`include "bsa_map.vh"
// Contract
// RQ1: idle after no access or hold end
// RQ2: address state always followed by data/wait
// RQ3: data/wait is final or wait state
// RQ4: hold entered on request, left when released
// RQ5: extra word cycle mirrors normal states
// RQ6: reset chooses idle or hold by request
// RQ7: idle starts access or hold by enable
// RQ8: not ready repeats data; word adds cycle
// RQ9: lock blocks hold until final cycle
// RQ10: transfer idle samples transfer request
// RQ11: leave idle on request, enable, no nmi
// RQ12: two-cycle read address then data then write
// RQ13: write address then write data, strobe off
// RQ14: fly-by address then fly-by data, strobe off
// RQ15: transfer ready merges internal and pin ready
// RQ16: release state then idle after service
// RQ17: higher master during block transfer forces hold
// RQ18: priority lock, refresh, external, dma, cpu
// RQ19: higher requester takes bus at boundary
// RQ20: refresh waits for external master release
// RQ21: hold refused in halt ack, selfref start
// RQ22: external master keeps request off at reset
// RQ23: word read low half first, high second
// RQ24: acknowledge and float bus in hold
module bsa_bus_arbiter #(
  parameter DW = 16                          // external data width
) (
  // clock and reset
  input  wire          clk_in,               // 250 MHz cpu clock
  input  wire          rst_in,               // async, active high
  // external bus master pins
  input  wire          hold_request_n_in,    // pin, active low
  output reg           hold_ack_n_out,       // pin, active low
  output reg           bus_oe_n_out,         // low while device drives bus
  input  wire          ready_n_in,           // pin, active low
  input  wire [DW-1:0] rdata_in,             // pin read data
  // cpu access side
  input  wire          cpu_req_in,           // access source present
  input  wire          cpu_word_in,          // word access
  input  wire          cpu_lock_in,          // bus lock sequence active
  input  wire          cpu_lock_last_in,     // last cycle of lock sequence
  input  wire          halt_ack_in,          // halt acknowledge cycle
  input  wire          selfref_start_in,     // self-refresh entry pulse
  output reg  [7:0]    cpu_state_out,        // cpu bus state
  output reg  [2*DW-1:0] cpu_rdata_out,      // captured read word
  output reg           cpu_done_out,         // one-cycle access done
  // refresh
  input  wire          refresh_req_in,       // refresh pending
  output reg           refresh_grant_out,    // refresh owns bus
  // transfer engine
  input  wire          dma_request_in,       // pin, active high
  input  wire          dma_sw_req_in,        // software request
  input  wire          dma_io_req_in,        // internal i/o request
  input  wire          dma_enable_in,        // engine enabled
  input  wire          dma_term_in,          // transfer terminated
  input  wire          dma_flyby_in,         // 1 fly-by, 0 two-cycle
  input  wire          dma_block_in,         // block transfer mode
  input  wire          nmi_n_in,             // pin, active low
  input  wire          wcu_ready_n_in,       // wait unit ready, active low
  output reg  [9:0]    dma_state_out,        // engine bus state
  output reg           dma_wstrobe_out,      // transfer write strobe
  output reg  [DW-1:0] dma_rdata_out,        // captured transfer read data
  output reg  [2:0]    owner_out             // current bus owner
);

  // synchronisers for pins
  reg [1:0] hreq_s_r;                        // hold request sync
  reg [1:0] rdy_s_r;                         // ready sync
  reg [1:0] dma_request_s_r;                        // transfer request sync
  reg [1:0] nmi_s_r;                         // nmi sync
  reg       hreq_fe_r;                       // hold request at falling edge
  reg       dma_request_fe_r;                       // transfer request at falling edge

  // state registers
  reg [7:0] cst_r;                           // cpu state
  reg [7:0] cst_nxt;
  reg [9:0] dst_r;                           // engine state
  reg [9:0] dst_nxt;
  reg [2:0] sref_cnt_r;                      // self-refresh block count
  reg       reset_seen_r;                    // reset state resolved
  reg       ack_drop_r;                      // refresh pending during hold
  reg       data_old_r;                      // cpu data state held past one edge
  reg       dma_old_r;                       // engine data state held past one edge

  // decoded conditions
  wire hreq     = hreq_s_r[1];               // hold requested
  wire rdy      = rdy_s_r[1];                // cpu ready
  // ready is trusted only once the data state has seen one edge
  wire rdy_ok   = rdy & data_old_r;          // RQ3 RQ8
  wire nmi_act  = ~nmi_s_r[1];               // nmi asserted
  wire dma_rdy  = rdy & dma_old_r & ~wcu_ready_n_in; // RQ15
  wire hold_dis = (cpu_lock_in & ~cpu_lock_last_in) | halt_ack_in
                | (sref_cnt_r != 3'h0);      // RQ9 RQ21
  wire hold_en  = ~hold_dis;
  wire hold_go  = hreq_fe_r & hold_en;       // sampled on falling edge
  wire dma_bus  = (owner_out == `BSA_OWN_DMA);
  wire dma_ask  = (dma_request_fe_r | dma_sw_req_in | dma_io_req_in)
                & ~dma_term_in & dma_enable_in & ~nmi_act; // RQ11
  wire dma_more = ~nmi_act & ~dma_term_in & dma_block_in;

  // one bus-state boundary check, used by arbiter
  function is_boundary;
    input [7:0] st;
    begin
      is_boundary = (st == `BSA_C_IDLE) | (st == `BSA_C_IDLE_X);
    end
  endfunction

  // two-flop synchronisers
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hreq_s_r <= 2'h0;
      rdy_s_r  <= 2'h0;
      dma_request_s_r <= 2'h0;
      nmi_s_r  <= 2'h3;
    end else begin
      hreq_s_r <= {hreq_s_r[0], ~hold_request_n_in};
      rdy_s_r  <= {rdy_s_r[0], ~ready_n_in};
      dma_request_s_r <= {dma_request_s_r[0], dma_request_in};
      nmi_s_r  <= {nmi_s_r[0], nmi_n_in};
    end
  end

  // falling-edge sampling of synchronised requests
  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hreq_fe_r <= 1'b0;
      dma_request_fe_r <= 1'b0;
    end else begin
      hreq_fe_r <= hreq;                     // RQ1 RQ3 RQ4
      dma_request_fe_r <= dma_request_s_r[1];              // RQ10
    end
  end

  // data-state age flags
  // the synchronised ready lags the pin by two edges, so at the first
  // edge of a new data state it still shows the answer of the previous
  // cycle; a flag that is set only after one edge spent in the same
  // data state masks that leftover and keeps wait states honest
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_old_r <= 1'b0;
      dma_old_r  <= 1'b0;
    end else begin
      // cpu side: normal or extra data state kept
      data_old_r <= (cst_r == `BSA_C_DATA || cst_r == `BSA_C_DATA_X)
                  & (cst_nxt == cst_r);
      // engine side: read, write or fly-by data state kept
      dma_old_r  <= (dst_r == `BSA_D_RDATA || dst_r == `BSA_D_WDATA ||
                     dst_r == `BSA_D_FDATA) & (dst_nxt == dst_r);
    end
  end

  // cpu bus-state next value
  // hold is only taken from idle, data or hold itself, never mid-address
  always @* begin
    cst_nxt = cst_r;
    case (cst_r)
      `BSA_C_IDLE, `BSA_C_IDLE_X: begin
        if (hold_go)
          cst_nxt = (cst_r == `BSA_C_IDLE) ? `BSA_C_HOLD : `BSA_C_HOLD_X; // RQ7
        else if (cst_r == `BSA_C_IDLE_X)
          cst_nxt = `BSA_C_ADDR_X;           // RQ5
        else if (cpu_req_in && owner_out == `BSA_OWN_CPU)
          cst_nxt = `BSA_C_ADDR;             // RQ7
      end
      `BSA_C_ADDR:   cst_nxt = `BSA_C_DATA;   // RQ2
      `BSA_C_ADDR_X: cst_nxt = `BSA_C_DATA_X; // RQ2 RQ5
      `BSA_C_DATA: begin
        if (!rdy_ok)
          cst_nxt = `BSA_C_DATA;             // RQ3 RQ8
        else if (cpu_word_in)
          cst_nxt = hold_go ? `BSA_C_HOLD_X : `BSA_C_ADDR_X; // RQ8
        else if (hold_go)
          cst_nxt = `BSA_C_HOLD;             // RQ4
        else if (cpu_req_in && owner_out == `BSA_OWN_CPU)
          cst_nxt = `BSA_C_ADDR;
        else
          cst_nxt = `BSA_C_IDLE;             // RQ1
      end
      `BSA_C_DATA_X: begin
        if (!rdy_ok)
          cst_nxt = `BSA_C_DATA_X;           // RQ3
        else if (hold_go)
          cst_nxt = `BSA_C_HOLD;
        else if (cpu_req_in && owner_out == `BSA_OWN_CPU)
          cst_nxt = `BSA_C_ADDR;
        else
          cst_nxt = `BSA_C_IDLE;             // RQ1
      end
      `BSA_C_HOLD:   if (!hreq_fe_r) cst_nxt = `BSA_C_IDLE;   // RQ4
      `BSA_C_HOLD_X: if (!hreq_fe_r) cst_nxt = `BSA_C_IDLE_X; // RQ4 RQ5
      default:       cst_nxt = `BSA_C_IDLE;
    endcase
  end

  // cpu state register; reset choice made after release
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cst_r        <= `BSA_C_IDLE;
      reset_seen_r <= 1'b0;
    end else if (!reset_seen_r) begin
      reset_seen_r <= 1'b1;
      cst_r        <= hreq ? `BSA_C_HOLD : `BSA_C_IDLE; // RQ6
    end else begin
      cst_r <= cst_nxt;
    end
  end

  // self-refresh entry refusal window
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      sref_cnt_r <= 3'h0;
    else if (selfref_start_in)
      sref_cnt_r <= `BSA_SELFREF_BLOCK;      // RQ21
    else if (sref_cnt_r != 3'h0)
      sref_cnt_r <= sref_cnt_r - 3'h1;
  end

  // cpu read capture and done strobe
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_rdata_out <= {2*DW{1'b0}};
      cpu_done_out  <= 1'b0;
    end else begin
      cpu_done_out <= 1'b0;
      // low half in the first cycle, done only for a single access
      if (cst_r == `BSA_C_DATA && rdy_ok) begin
        cpu_rdata_out[DW-1:0] <= rdata_in;   // RQ3 RQ23
        cpu_done_out          <= ~cpu_word_in;
      end
      // high half in the extra cycle ends a word access
      if (cst_r == `BSA_C_DATA_X && rdy_ok) begin
        cpu_rdata_out[2*DW-1:DW] <= rdata_in; // RQ23
        cpu_done_out             <= 1'b1;
      end
    end
  end

  // transfer engine next state
  // the engine only moves onto the bus once the arbiter names it owner;
  // an nmi in ready or hold drops the request back to idle
  always @* begin
    dst_nxt = dst_r;
    case (dst_r)
      `BSA_D_IDLE:  if (dma_ask) dst_nxt = `BSA_D_READY; // RQ11
      `BSA_D_READY: begin
        if (nmi_act)
          dst_nxt = `BSA_D_IDLE;
        else if (dma_bus)
          dst_nxt = dma_flyby_in ? `BSA_D_FADDR : `BSA_D_RADDR; // RQ12 RQ14
      end
      `BSA_D_RADDR: dst_nxt = `BSA_D_RDATA;  // RQ12
      `BSA_D_RDATA: if (dma_rdy) dst_nxt = `BSA_D_WADDR; // RQ12 RQ15
      `BSA_D_WADDR: dst_nxt = `BSA_D_WDATA;  // RQ13
      `BSA_D_FADDR: dst_nxt = `BSA_D_FDATA;  // RQ14
      `BSA_D_WDATA, `BSA_D_FDATA: begin
        if (dma_rdy) begin
          if (!dma_more)
            dst_nxt = `BSA_D_REL;            // RQ16
          else if (!dma_bus)
            dst_nxt = `BSA_D_HOLD;           // RQ17
          else
            dst_nxt = dma_flyby_in ? `BSA_D_FADDR : `BSA_D_RADDR;
        end
      end
      `BSA_D_HOLD: begin
        if (nmi_act)
          dst_nxt = `BSA_D_IDLE;
        else if (dma_bus)
          dst_nxt = dma_flyby_in ? `BSA_D_FADDR : `BSA_D_RADDR;
      end
      `BSA_D_REL:   dst_nxt = `BSA_D_IDLE;   // RQ16
      default:      dst_nxt = `BSA_D_IDLE;
    endcase
  end

  // transfer engine state, strobe and capture
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dst_r           <= `BSA_D_IDLE;
      dma_wstrobe_out <= 1'b0;
      dma_rdata_out   <= {DW{1'b0}};
    end else begin
      dst_r <= dst_nxt;
      // strobe asserted in write or fly-by data, dropped at last one
      dma_wstrobe_out <= (dst_nxt == `BSA_D_WDATA || dst_nxt == `BSA_D_FDATA)
                       & ~(dma_rdy & (dst_r == `BSA_D_WDATA || dst_r == `BSA_D_FDATA)); // RQ13 RQ14
      if (dst_r == `BSA_D_RDATA && dma_rdy)
        dma_rdata_out <= rdata_in;           // RQ12
    end
  end

  // arbiter: reassign at cpu idle boundaries and engine gaps
  // refresh is never granted while the external master still asks,
  // so a held master is told by a dropped acknowledge instead
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      owner_out         <= `BSA_OWN_CPU;
      refresh_grant_out <= 1'b0;
      ack_drop_r        <= 1'b0;
    end else begin
      ack_drop_r <= (cst_r == `BSA_C_HOLD || cst_r == `BSA_C_HOLD_X)
                  & refresh_req_in;          // RQ20
      if (cpu_lock_in && owner_out == `BSA_OWN_CPU)
        owner_out <= `BSA_OWN_LOCK;          // RQ18
      else if (owner_out == `BSA_OWN_LOCK && !cpu_lock_in && is_boundary(cst_r))
        owner_out <= `BSA_OWN_CPU;
      else if (owner_out != `BSA_OWN_LOCK && is_boundary(cst_r)) begin // RQ19
        if (refresh_req_in && !hreq) begin
          owner_out         <= `BSA_OWN_REF; // RQ18 RQ20
          refresh_grant_out <= 1'b1;
        end else if (hreq && hold_en) begin
          owner_out         <= `BSA_OWN_EXT;
          refresh_grant_out <= 1'b0;
        end else if (dst_r != `BSA_D_IDLE && dst_r != `BSA_D_REL) begin
          owner_out         <= `BSA_OWN_DMA;
          refresh_grant_out <= 1'b0;
        end else begin
          owner_out         <= `BSA_OWN_CPU;
          refresh_grant_out <= 1'b0;
        end
      end else if (owner_out == `BSA_OWN_DMA && (hreq_fe_r || refresh_req_in || cpu_lock_in)) begin
        owner_out <= `BSA_OWN_CPU;           // RQ17 RQ19 yield to higher
      end
    end
  end

  // hold acknowledge and bus float
  // all outputs follow the next state so they line up with the state
  // registers; the state outputs are plain copies for the far side
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_ack_n_out <= 1'b1;
      bus_oe_n_out   <= 1'b1;
      cpu_state_out  <= `BSA_C_IDLE;
      dma_state_out  <= `BSA_D_IDLE;
    end else begin
      hold_ack_n_out <= ~((cst_nxt == `BSA_C_HOLD || cst_nxt == `BSA_C_HOLD_X)
                          & ~ack_drop_r);    // RQ24 RQ20
      bus_oe_n_out   <= ~(cst_nxt == `BSA_C_ADDR || cst_nxt == `BSA_C_DATA ||
                          cst_nxt == `BSA_C_ADDR_X || cst_nxt == `BSA_C_DATA_X); // RQ24
      cpu_state_out  <= cst_nxt;
      dma_state_out  <= dst_nxt;
    end
  end

endmodule // bsa_bus_arbiter

/* File: bsa_checker_props.sv */
`timescale 1ns/100ps
`include "bsa_map.vh"
// watches both bus sequencers and the hold handshake
module bsa_checker (
  // clock and reset
  input wire       clk_in,
  input wire       rst_in,
  // watched ports
  input wire       hold_ack_n_out,
  input wire       bus_oe_n_out,
  input wire       refresh_req_in,
  input wire       cpu_lock_in,
  input wire       cpu_lock_last_in,
  input wire       wcu_ready_n_in,
  input wire       cpu_done_out,
  input wire [7:0] cpu_state_out,
  input wire [9:0] dma_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // short aliases of the two state vectors
  wire [7:0] cs = cpu_state_out;
  wire [9:0] ds = dma_state_out;
  // last cycle of a transfer read phase
  sequence s_rd_end;
    ds == `BSA_D_RDATA ##1 ds != `BSA_D_RDATA;
  endsequence
  // lock held outside its final cycle
  sequence s_locked;
    (cpu_lock_in && !cpu_lock_last_in) [*4];
  endsequence
  a_addr_to_data: assert property (cs == `BSA_C_ADDR |=> cs == `BSA_C_DATA)
    else $error("address state not followed by data state");
  a_extra_to_data: assert property (cs == `BSA_C_ADDR_X |=> cs == `BSA_C_DATA_X)
    else $error("extra address state not followed by extra data state");
  a_done_after_data: assert property (cpu_done_out |-> $past(cs) == `BSA_C_DATA || $past(cs) == `BSA_C_DATA_X)
    else $error("access done without a data state");
  a_hold_floats: assert property (cs == `BSA_C_HOLD && $past(cs) == `BSA_C_HOLD |-> bus_oe_n_out)
    else $error("bus driven during hold");
  a_hold_ack_low: assert property ((cs == `BSA_C_HOLD && !refresh_req_in) [*3] |-> !hold_ack_n_out)
    else $error("hold without acknowledge");
  a_lock_blocks: assert property (s_locked |-> cs != `BSA_C_HOLD)
    else $error("hold taken inside locked sequence");
  a_read_to_write: assert property (s_rd_end |-> ds == `BSA_D_WADDR)
    else $error("read phase not followed by write address");
  a_write_chain: assert property (ds == `BSA_D_WADDR |=> ds == `BSA_D_WDATA)
    else $error("write address not followed by write data");
  a_flyby_chain: assert property (ds == `BSA_D_FADDR |=> ds == `BSA_D_FDATA)
    else $error("fly-by address not followed by fly-by data");
  a_release_idle: assert property (ds == `BSA_D_REL |=> ds == `BSA_D_IDLE)
    else $error("release state not followed by idle");
  a_wait_repeats: assert property (ds == `BSA_D_RDATA && wcu_ready_n_in |=> ds == `BSA_D_RDATA)
    else $error("read data state left while not ready");
endmodule // bsa_checker
bind bsa_bus_arbiter bsa_checker chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .hold_ack_n_out(hold_ack_n_out), .bus_oe_n_out(bus_oe_n_out),
  .refresh_req_in(refresh_req_in), .cpu_lock_in(cpu_lock_in), .cpu_lock_last_in(cpu_lock_last_in),
  .wcu_ready_n_in(wcu_ready_n_in), .cpu_done_out(cpu_done_out), .cpu_state_out(cpu_state_out),
  .dma_state_out(dma_state_out));

/* File: bsa_far_side.sv */
`timescale 1ns/100ps
`include "bsa_map.vh"
// memory answering with ready and data, plus an external bus master
module bsa_far_side (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // bus view
  input  wire [7:0]  cpu_state_in,
  input  wire [9:0]  dma_state_in,
  input  wire        hold_ack_n_in,
  input  wire [3:0]  waits_in,
  input  wire        want_hold_in,
  // answers
  output wire        ready_n_out,
  output wire [15:0] rdata_out,
  output reg         hold_request_n_out
);
  reg [15:0] cyc_r;  // bus cycles started, write address excluded
  reg [3:0]  wcnt_r; // cycles spent in data phase
  reg        ph_r;   // toggles every cycle
  reg        ack_r;  // acknowledge seen for our request
  reg        yld_r;  // gave way to refresh
  wire start = |(cpu_state_in & 8'h22) || |(dma_state_in & 10'h044);
  wire in_data = |(cpu_state_in & 8'h44) || |(dma_state_in & 10'h0a8);
  // ready after the asked wait states; data changes each cycle when idle
  assign ready_n_out = !(in_data && wcnt_r >= waits_in);
  assign rdata_out = in_data ? 16'ha500 + cyc_r : {16{ph_r}} ^ 16'h5a5a;
  // cycle counting and hold handshake
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_r <= 16'h0;
      wcnt_r <= 4'h0;
      ph_r <= 1'b0;
      ack_r <= 1'b0;
      yld_r <= 1'b0;
      hold_request_n_out <= 1'b1;
    end else begin
      cyc_r <= cyc_r + {15'h0, start};
      wcnt_r <= in_data ? wcnt_r + 4'h1 : 4'h0;
      ph_r <= ~ph_r;
      if (!hold_ack_n_in && !hold_request_n_out) ack_r <= 1'b1;
      if (ack_r && hold_ack_n_in) begin
        yld_r <= 1'b1;
        ack_r <= 1'b0;
      end
      if (!want_hold_in) yld_r <= 1'b0;
      hold_request_n_out <= !(want_hold_in && !yld_r && !(ack_r && hold_ack_n_in));
    end
  end
endmodule // bsa_far_side

/* File: bsa_map.vh */
`ifndef BSA_MAP_VH
`define BSA_MAP_VH
// cpu bus states, one-hot
`define BSA_C_IDLE      8'h01
`define BSA_C_ADDR      8'h02
`define BSA_C_DATA      8'h04
`define BSA_C_HOLD      8'h08
`define BSA_C_IDLE_X    8'h10
`define BSA_C_ADDR_X    8'h20
`define BSA_C_DATA_X    8'h40
`define BSA_C_HOLD_X    8'h80
// transfer engine states, one-hot
`define BSA_D_IDLE      10'h001
`define BSA_D_READY     10'h002
`define BSA_D_RADDR     10'h004
`define BSA_D_RDATA     10'h008
`define BSA_D_WADDR     10'h010
`define BSA_D_WDATA     10'h020
`define BSA_D_FADDR     10'h040
`define BSA_D_FDATA     10'h080
`define BSA_D_REL       10'h100
`define BSA_D_HOLD      10'h200
// owner codes
`define BSA_OWN_CPU     3'h0
`define BSA_OWN_LOCK    3'h1
`define BSA_OWN_REF     3'h2
`define BSA_OWN_EXT     3'h3
`define BSA_OWN_DMA     3'h4
// clocks without hold acceptance at self-refresh entry
`define BSA_SELFREF_BLOCK 3'h6
`endif

/* File: bus_state_and_arbitration_tb.sv */
`timescale 1ns/100ps
`include "bsa_map.vh"
module bus_state_and_arbitration_tb;
  // design pins under their port names
  logic        clk_in, rst_in, hold_request_n_in, ready_n_in, cpu_req_in, cpu_word_in;
  logic        cpu_lock_in, cpu_lock_last_in, halt_ack_in, selfref_start_in, refresh_req_in;
  logic        dma_request_in, dma_sw_req_in, dma_io_req_in, dma_enable_in, dma_term_in;
  logic        dma_flyby_in, dma_block_in, nmi_n_in, wcu_ready_n_in, cpu_done_out;
  logic        hold_ack_n_out, bus_oe_n_out, refresh_grant_out, dma_wstrobe_out;
  logic [15:0] rdata_in, dma_rdata_out;
  logic [31:0] cpu_rdata_out;
  logic [7:0]  cpu_state_out;
  logic [9:0]  dma_state_out;
  logic [2:0]  owner_out;
  logic [3:0]  waits;     // far side wait states
  logic        want_hold; // far master wants the bus
  int          n_fail = 0, check_count = 0, ncyc = 0;
  bsa_bus_arbiter #(.DW(16)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .hold_request_n_in(hold_request_n_in), .hold_ack_n_out(hold_ack_n_out),
    .bus_oe_n_out(bus_oe_n_out), .ready_n_in(ready_n_in), .rdata_in(rdata_in),
    .cpu_req_in(cpu_req_in), .cpu_word_in(cpu_word_in), .cpu_lock_in(cpu_lock_in),
    .cpu_lock_last_in(cpu_lock_last_in), .halt_ack_in(halt_ack_in),
    .selfref_start_in(selfref_start_in), .cpu_state_out(cpu_state_out),
    .cpu_rdata_out(cpu_rdata_out), .cpu_done_out(cpu_done_out),
    .refresh_req_in(refresh_req_in), .refresh_grant_out(refresh_grant_out),
    .dma_request_in(dma_request_in), .dma_sw_req_in(dma_sw_req_in),
    .dma_io_req_in(dma_io_req_in), .dma_enable_in(dma_enable_in), .dma_term_in(dma_term_in),
    .dma_flyby_in(dma_flyby_in), .dma_block_in(dma_block_in), .nmi_n_in(nmi_n_in),
    .wcu_ready_n_in(wcu_ready_n_in), .dma_state_out(dma_state_out),
    .dma_wstrobe_out(dma_wstrobe_out), .dma_rdata_out(dma_rdata_out), .owner_out(owner_out));
  bsa_far_side far_u (.clk_in(clk_in), .rst_in(rst_in), .cpu_state_in(cpu_state_out),
    .dma_state_in(dma_state_out), .hold_ack_n_in(hold_ack_n_out), .waits_in(waits),
    .want_hold_in(want_hold), .ready_n_out(ready_n_in), .rdata_out(rdata_in),
    .hold_request_n_out(hold_request_n_in));
  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // bounded waits, sampled just after the edge
  task automatic wait_cpu(input logic [7:0] s);
    #1;
    repeat (80) if (cpu_state_out !== s) @(posedge clk_in) #1;
  endtask
  task automatic wait_dma(input logic [9:0] s);
    #1;
    repeat (80) if (dma_state_out !== s) @(posedge clk_in) #1;
  endtask
  // one cpu read, single or word, with wait states
  task automatic t_read(input logic word, input logic [3:0] w);
    logic [15:0] lo, hi;
    ncyc++;
    lo = 16'ha500 + ncyc[15:0];
    hi = 16'ha501 + ncyc[15:0];
    ncyc += word;
    @(posedge clk_in);
    waits <= w;
    cpu_word_in <= word;
    cpu_req_in <= 1'b1;
    wait_cpu(`BSA_C_ADDR);
    @(posedge clk_in) cpu_req_in <= 1'b0;
    wait_cpu(`BSA_C_DATA);
    chk(bus_oe_n_out, 1'b0, "bus not driven in data state");
    repeat (40) if (cpu_done_out !== 1'b1) @(posedge clk_in) #1;
    chk(cpu_done_out, 1'b1, "access never completed");
    chk(word ? cpu_rdata_out : {16'h0, cpu_rdata_out[15:0]}, {word ? hi : 16'h0, lo}, "read data");
  endtask
  // external master takes the bus, then refresh makes it yield
  task automatic t_hold;
    @(posedge clk_in);
    want_hold <= 1'b1;
    wait_cpu(`BSA_C_HOLD);
    chk(cpu_state_out, `BSA_C_HOLD, "hold not entered");
    repeat (3) @(posedge clk_in);
    refresh_req_in <= 1'b1;
    #1;
    chk(hold_ack_n_out, 1'b0, "hold not acknowledged");
    chk(bus_oe_n_out, 1'b1, "bus driven in hold");
    chk(owner_out, `BSA_OWN_EXT, "external master not owner");
    repeat (40) if (refresh_grant_out !== 1'b1) @(posedge clk_in) #1;
    chk(refresh_grant_out, 1'b1, "refresh never granted");
    chk(hold_request_n_in, 1'b1, "refresh took bus from held master");
    @(posedge clk_in);
    refresh_req_in <= 1'b0;
    want_hold <= 1'b0;
    wait_cpu(`BSA_C_IDLE);
    chk(cpu_state_out, `BSA_C_IDLE, "idle not resumed after hold");
  endtask
  // hold refused under lock, halt acknowledge, self-refresh entry
  task automatic t_refuse(input int k);
    @(posedge clk_in);
    want_hold <= 1'b1;
    cpu_lock_in <= (k == 0);
    halt_ack_in <= (k == 1);
    selfref_start_in <= (k == 2);
    @(posedge clk_in) selfref_start_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk(cpu_state_out == `BSA_C_HOLD, 1'b0, "hold accepted while refused");
    @(posedge clk_in);
    cpu_lock_last_in <= (k == 0);
    halt_ack_in <= 1'b0;
    wait_cpu(`BSA_C_HOLD);
    chk(cpu_state_out, `BSA_C_HOLD, "hold not accepted after refusal");
    @(posedge clk_in);
    cpu_lock_in <= 1'b0;
    cpu_lock_last_in <= 1'b0;
    want_hold <= 1'b0;
    wait_cpu(`BSA_C_IDLE);
  endtask
  // transfer blocked first (nmi or disabled), then run with waits
  task automatic t_dma(input logic fly);
    @(posedge clk_in);
    dma_flyby_in <= fly;
    dma_request_in <= !fly;
    dma_sw_req_in <= fly;
    nmi_n_in <= fly;
    dma_enable_in <= !fly;
    wcu_ready_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    chk(dma_state_out, `BSA_D_IDLE, "transfer started while blocked");
    @(posedge clk_in);
    nmi_n_in <= 1'b1;
    dma_enable_in <= 1'b1;
    ncyc++;
    wait_dma(fly ? `BSA_D_FADDR : `BSA_D_RADDR);
    chk(owner_out, `BSA_OWN_DMA, "transfer engine not owner");
    @(posedge clk_in);
    dma_request_in <= 1'b0;
    dma_sw_req_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    wcu_ready_n_in <= 1'b0;
    if (!fly) begin
      wait_dma(`BSA_D_WADDR);
      chk(dma_rdata_out, 16'ha500 + ncyc[15:0], "transfer read data");
    end
    wait_dma(fly ? `BSA_D_FDATA : `BSA_D_WDATA);
    chk(dma_wstrobe_out, 1'b1, "write strobe not active in data state");
    wait_dma(`BSA_D_REL);
    chk(dma_wstrobe_out, 1'b0, "write strobe left active");
    wait_dma(`BSA_D_IDLE);
    chk(dma_state_out, `BSA_D_IDLE, "engine not back in idle");
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #20000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
  // main sequence
  initial begin
    {cpu_req_in, cpu_word_in, cpu_lock_in, cpu_lock_last_in, halt_ack_in, selfref_start_in} = '0;
    {refresh_req_in, dma_request_in, dma_sw_req_in, dma_io_req_in, dma_term_in} = '0;
    {dma_flyby_in, dma_block_in, wcu_ready_n_in, want_hold} = '0;
    {dma_enable_in, nmi_n_in, rst_in} = 3'h7;
    waits = 4'h0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk(cpu_state_out, `BSA_C_IDLE, "state after reset");
    chk(hold_ack_n_out, 1'b1, "acknowledge after reset");
    t_read(1'b0, 4'h0);
    t_read(1'b1, 4'h2);
    t_hold();
    for (int k = 0; k < 3; k++) t_refuse(k);
    t_dma(1'b0);
    t_dma(1'b1);
    give_verdict();
  end
endmodule // bus_state_and_arbitration_tb
